/* hw/mf_cfg.svh */
// constants for the multi-function output selector
`ifndef PIN_SEL_CFG_SVH
`define PIN_SEL_CFG_SVH

// ---------------------------------------------------------------
// register field positions
// ---------------------------------------------------------------
`define PSEL_FIELD_LSB      1
`define PSEL_FIELD_MSB      2
`define PSEL_USER_OUT_BIT   3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PSEL_USER_OUT_RST   1'b1
`define PSEL_FIELD_RST      2'h0
`define PSEL_PIN_IDLE_N     1'b1

// ---------------------------------------------------------------
// selection codes
// ---------------------------------------------------------------
`define PSEL_CODE_USER_OUT  2'h0
`define PSEL_CODE_RATE_CLK  2'h1
`define PSEL_CODE_RX_READY  2'h2
`define PSEL_CODE_SPARE     2'h3

`endif

/* hw/mf_pkg.sv */
// types shared by the multi-function output selector
`include "mf_cfg.svh"

package pin_sel_pkg;

  // ---------------------------------------------------------------
  // function chosen for one multi-function pin
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_USER_OUT = `PSEL_CODE_USER_OUT,  // inverted user output bit
    SEL_RATE_CLK = `PSEL_CODE_RATE_CLK,  // 16x rate clock
    SEL_RX_READY = `PSEL_CODE_RX_READY,  // receive ready, active low
    SEL_SPARE    = `PSEL_CODE_SPARE      // unassigned, acts as user out
  } func_sel_t;

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  typedef struct packed {
    func_sel_t sel;         // selection field
    logic    user_out_two;  // modem control bit 3
    logic    pin_n;         // registered pin level
  } chan_state_t;

  // ---------------------------------------------------------------
  // top-level state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ring_sync;  // ring indicator synchroniser chain
    logic       ring_n;     // filtered ring indicator level
  } top_state_t;

endpackage : pin_sel_pkg

/* hw/mf_channel_mux.sv */
// one channel's selection field, user output bit and pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "mf_cfg.svh"

module chan_pin_mux (
  input  wire logic       i_ref_clk,          // block clock
  input  wire logic       i_rst_n,            // synchronised reset
  input  wire logic       i_alt_func_write,   // alternate function write
  input  wire logic [7:0] i_alt_func_wdata,   // alternate function data
  input  wire logic       i_modem_ctrl_write, // modem control write
  input  wire logic [7:0] i_modem_ctrl_wdata, // modem control data
  input  wire logic       i_rate_clock_16x,   // 16x rate clock, same domain
  input  wire logic       i_receive_ready_n,  // receive ready, active low
  output logic            o_multi_output_n,   // multi-function pin
  output logic [1:0]      o_sel,              // current selection
  output logic            o_user_out_two      // current modem bit 3
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pin_sel_pkg::chan_state_t st;       // registered state
  pin_sel_pkg::chan_state_t next_st;  // next state

  // field updates and output selection
  always_comb begin
    next_st = st;
    // selection field from bits 2:1
    if (i_alt_func_write) begin
      next_st.sel = pin_sel_pkg::func_sel_t'(
        i_alt_func_wdata[`PSEL_FIELD_MSB:`PSEL_FIELD_LSB]);
    end
    // user output bit 3
    if (i_modem_ctrl_write) begin
      next_st.user_out_two = i_modem_ctrl_wdata[`PSEL_USER_OUT_BIT];
    end
    // one function drives the pin
    unique case (st.sel)
      pin_sel_pkg::SEL_RATE_CLK: begin
        next_st.pin_n = i_rate_clock_16x;
      end
      pin_sel_pkg::SEL_RX_READY: begin
        next_st.pin_n = i_receive_ready_n;
      end
      default: begin
        // user out and spare code: low while bit 3 is one
        next_st.pin_n = ~st.user_out_two;
      end
    endcase
  end

  // register the state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st.sel          <= pin_sel_pkg::func_sel_t'(`PSEL_FIELD_RST);
      st.user_out_two <= `PSEL_USER_OUT_RST;
      st.pin_n        <= `PSEL_PIN_IDLE_N;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign o_multi_output_n = st.pin_n;
  assign o_sel            = st.sel;
  assign o_user_out_two   = st.user_out_two;

endmodule : chan_pin_mux
`default_nettype wire

/* hw/uart_multi_output_select.sv */
// top of the dual-channel multi-function output selector
`timescale 1ns/1ps
`default_nettype none
`include "mf_cfg.svh"

// Functional notes
// - pin driven by function chosen in bits 2:1
// - user function: pin low while bit 3 set
// - modem control bit 3 resets to one
// - rate function: 16x clock on pin
// - ready function: active-low receive ready on pin
// - ring indicator B is status only
module uart_multi_output_select #(
  parameter int unsigned NUM_CHAN = 2  // channels A and B
) (
  input  wire logic       i_ref_clk,              // block clock
  input  wire logic       i_rst_n,                // async reset
  input  wire logic       i_chan_a_alt_func_write,   // A selection write
  input  wire logic [7:0] i_chan_a_alt_func_wdata,   // A selection data
  input  wire logic       i_chan_a_modem_ctrl_write, // A modem ctrl write
  input  wire logic [7:0] i_chan_a_modem_ctrl_wdata, // A modem ctrl data
  input  wire logic       i_chan_a_rate_clock_16x,// A 16x rate clock
  input  wire logic       i_chan_a_receive_ready_n,// A receive ready
  input  wire logic       i_chan_b_alt_func_write,   // B selection write
  input  wire logic [7:0] i_chan_b_alt_func_wdata,   // B selection data
  input  wire logic       i_chan_b_modem_ctrl_write, // B modem ctrl write
  input  wire logic [7:0] i_chan_b_modem_ctrl_wdata, // B modem ctrl data
  input  wire logic       i_chan_b_rate_clock_16x,// B 16x rate clock
  input  wire logic       i_chan_b_receive_ready_n,// B receive ready
  input  wire logic       i_chan_b_ring_indicator_n,// B ring pin
  output logic            o_chan_a_multi_output_n,// A multi pin
  output logic            o_chan_b_multi_output_n,// B multi pin
  output logic [1:0]      o_chan_a_sel,           // A selection
  output logic [1:0]      o_chan_b_sel,           // B selection
  output logic            o_chan_a_user_out_two,  // A modem bit 3
  output logic            o_chan_b_user_out_two,  // B modem bit 3
  output logic            o_chan_b_ring_status_n  // B ring status
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_chain;  // two-stage release
  logic       rst_n;      // synchronised reset

  // assert at once, release after two edges
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_chain <= 2'h0;
    end else begin
      rst_chain <= {rst_chain[0], 1'b1};
    end
  end

  assign rst_n = rst_chain[1];

  // ---------------------------------------------------------------
  // ring indicator input
  // ---------------------------------------------------------------
  pin_sel_pkg::top_state_t st;       // registered state
  pin_sel_pkg::top_state_t next_st;  // next state

  // three-stage sync; level moves when stages two and three agree
  always_comb begin
    next_st           = st;
    next_st.ring_sync = {st.ring_sync[1:0], i_chan_b_ring_indicator_n};
    if (st.ring_sync[1] == st.ring_sync[2]) begin
      next_st.ring_n = st.ring_sync[2];
    end
  end

  // register the state; pin idles high
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.ring_sync <= 3'h7;
      st.ring_n    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // status only; reaches no receive or transmit path
  assign o_chan_b_ring_status_n = st.ring_n;

  // ---------------------------------------------------------------
  // per-channel multiplexers
  // ---------------------------------------------------------------
  logic       alt_func_write   [NUM_CHAN];  // selection write strobes
  logic [7:0] alt_func_wdata   [NUM_CHAN];  // selection data
  logic       modem_ctrl_write [NUM_CHAN];  // modem ctrl write strobes
  logic [7:0] modem_ctrl_wdata [NUM_CHAN];  // modem ctrl data
  logic       rate_clk     [NUM_CHAN];  // rate clocks
  logic       rx_ready_n   [NUM_CHAN];  // receive ready levels
  logic       pin_n        [NUM_CHAN];  // pin levels
  logic [1:0] sel          [NUM_CHAN];  // selections
  logic       user_out_two [NUM_CHAN];  // modem bit 3 copies

  // gather channel A and B ports
  assign alt_func_write[0]   = i_chan_a_alt_func_write;
  assign alt_func_wdata[0]   = i_chan_a_alt_func_wdata;
  assign modem_ctrl_write[0] = i_chan_a_modem_ctrl_write;
  assign modem_ctrl_wdata[0] = i_chan_a_modem_ctrl_wdata;
  assign rate_clk[0]   = i_chan_a_rate_clock_16x;
  assign rx_ready_n[0] = i_chan_a_receive_ready_n;
  assign alt_func_write[1]   = i_chan_b_alt_func_write;
  assign alt_func_wdata[1]   = i_chan_b_alt_func_wdata;
  assign modem_ctrl_write[1] = i_chan_b_modem_ctrl_write;
  assign modem_ctrl_wdata[1] = i_chan_b_modem_ctrl_wdata;
  assign rate_clk[1]   = i_chan_b_rate_clock_16x;
  assign rx_ready_n[1] = i_chan_b_receive_ready_n;

  // one independent selector per channel
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    chan_pin_mux u_mux (
      .i_ref_clk          (i_ref_clk),
      .i_rst_n            (rst_n),
      .i_alt_func_write   (alt_func_write[c]),
      .i_alt_func_wdata   (alt_func_wdata[c]),
      .i_modem_ctrl_write (modem_ctrl_write[c]),
      .i_modem_ctrl_wdata (modem_ctrl_wdata[c]),
      .i_rate_clock_16x   (rate_clk[c]),
      .i_receive_ready_n  (rx_ready_n[c]),
      .o_multi_output_n   (pin_n[c]),
      .o_sel              (sel[c]),
      .o_user_out_two     (user_out_two[c])
    );
  end

  // scatter to channel ports
  assign o_chan_a_multi_output_n = pin_n[0];
  assign o_chan_b_multi_output_n = pin_n[1];
  assign o_chan_a_sel            = sel[0];
  assign o_chan_b_sel            = sel[1];
  assign o_chan_a_user_out_two   = user_out_two[0];
  assign o_chan_b_user_out_two   = user_out_two[1];

endmodule : uart_multi_output_select
`default_nettype wire

/* test/mf_select_properties.sv */
// concurrent checks on the multi-function output selector ports
`timescale 1ns/1ps
`default_nettype none
module pin_select_props (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_chan_a_alt_func_write,
  input wire logic [7:0] i_chan_a_alt_func_wdata,
  input wire logic       i_chan_a_modem_ctrl_write,
  input wire logic [7:0] i_chan_a_modem_ctrl_wdata,
  input wire logic       i_chan_a_rate_clock_16x,
  input wire logic       i_chan_b_alt_func_write,
  input wire logic       i_chan_b_receive_ready_n,
  input wire logic       i_chan_b_ring_indicator_n,
  input wire logic       o_chan_a_multi_output_n,
  input wire logic       o_chan_b_multi_output_n,
  input wire logic [1:0] o_chan_a_sel,
  input wire logic [1:0] o_chan_b_sel,
  input wire logic       o_chan_a_user_out_two,
  input wire logic       o_chan_b_user_out_two,
  input wire logic       o_chan_b_ring_status_n
);
  logic [1:0] rcnt;  // edges since reset release, saturates
  logic       ok;    // internal reset surely gone
  // count edges so checks skip the two-flop release
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) rcnt <= 2'h0;
    else if (rcnt != 2'h3) rcnt <= rcnt + 2'h1;
  end
  assign ok = (rcnt == 2'h3);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ring input held low for five samples
  sequence ring_low_s;
    (!i_chan_b_ring_indicator_n) [*5];
  endsequence
  a_sel_load: assert property (ok && i_chan_a_alt_func_write
    |=> o_chan_a_sel == $past(i_chan_a_alt_func_wdata[2:1]))
    else $error("sel");
  a_bit_load: assert property (ok && i_chan_a_modem_ctrl_write
    |=> o_chan_a_user_out_two == $past(i_chan_a_modem_ctrl_wdata[3]))
    else $error("bit3");
  a_reset_value: assert property (rcnt == 2'h1
    |-> o_chan_a_user_out_two && o_chan_b_user_out_two) else $error("rst");
  a_user_pin: assert property (ok && o_chan_a_sel == 2'h0
    |=> o_chan_a_multi_output_n == !$past(o_chan_a_user_out_two))
    else $error("user pin");
  a_rate_pin: assert property (ok && o_chan_a_sel == 2'h1
    |=> o_chan_a_multi_output_n == $past(i_chan_a_rate_clock_16x))
    else $error("rate pin");
  a_ready_pin: assert property (ok && o_chan_b_sel == 2'h2
    |=> o_chan_b_multi_output_n == $past(i_chan_b_receive_ready_n))
    else $error("ready pin");
  a_spare_pin: assert property (ok && o_chan_b_sel == 2'h3
    |=> o_chan_b_multi_output_n == !$past(o_chan_b_user_out_two))
    else $error("spare pin");
  a_ring_status: assert property (ok throughout ring_low_s
    |-> !o_chan_b_ring_status_n) else $error("ring");
  a_chan_apart: assert property (ok && i_chan_a_alt_func_write
    && !i_chan_b_alt_func_write |=> $stable(o_chan_b_sel))
    else $error("apart");
endmodule : pin_select_props
bind uart_multi_output_select pin_select_props pin_select_props_i (
  .i_ref_clk                 (i_ref_clk),
  .i_rst_n                   (i_rst_n),
  .i_chan_a_alt_func_write   (i_chan_a_alt_func_write),
  .i_chan_a_alt_func_wdata   (i_chan_a_alt_func_wdata),
  .i_chan_a_modem_ctrl_write (i_chan_a_modem_ctrl_write),
  .i_chan_a_modem_ctrl_wdata (i_chan_a_modem_ctrl_wdata),
  .i_chan_a_rate_clock_16x   (i_chan_a_rate_clock_16x),
  .i_chan_b_alt_func_write   (i_chan_b_alt_func_write),
  .i_chan_b_receive_ready_n  (i_chan_b_receive_ready_n),
  .i_chan_b_ring_indicator_n (i_chan_b_ring_indicator_n),
  .o_chan_a_multi_output_n   (o_chan_a_multi_output_n),
  .o_chan_b_multi_output_n   (o_chan_b_multi_output_n),
  .o_chan_a_sel              (o_chan_a_sel),
  .o_chan_b_sel              (o_chan_b_sel),
  .o_chan_a_user_out_two     (o_chan_a_user_out_two),
  .o_chan_b_user_out_two     (o_chan_b_user_out_two),
  .o_chan_b_ring_status_n    (o_chan_b_ring_status_n)
);
`default_nettype wire

/* test/dma_pin_watch.sv */
// far-side monitor counting rising edges on a multi-function pin
`timescale 1ns/1ps
`default_nettype none
module dma_pin_watch (
  input  wire logic       i_ref_clk,  // block clock
  input  wire logic       i_clear,    // restart the count
  input  wire logic       i_pin_n,    // watched pin
  output logic      [7:0] o_rises     // rising edges seen
);
  logic prev;  // pin level one edge ago
  // edge counter, cleared on request
  always_ff @(posedge i_ref_clk) begin
    prev <= i_pin_n;
    if (i_clear) o_rises <= 8'h00;
    else if (i_pin_n && !prev) o_rises <= o_rises + 8'h01;
  end
endmodule : dma_pin_watch
`default_nettype wire

/* test/uart_multi_output_select_test.sv */
// self-checking bench for the multi-function output selector
`timescale 1ns/1ps
`default_nettype none
module uart_multi_output_select_test;
  logic       clk = 1'b0;       // 250 MHz clock
  logic       rst_n = 1'b0;     // async reset
  logic [1:0] func_w = 2'h0;    // selection strobes
  logic [1:0] ctrl_w = 2'h0;    // modem control strobes
  logic [7:0] func_d [2] = '{8'h00, 8'h00};
  logic [7:0] ctrl_d [2] = '{8'h00, 8'h00};
  logic [1:0] rate = 2'h0;      // rate clocks
  logic [1:0] rdy = 2'h3;       // receive ready levels
  logic       ring_n = 1'b1;    // ring input
  logic       clr = 1'b1;       // monitor clear
  wire  [1:0] pin;              // multi-function pins
  wire        ring_st;          // ring status
  wire  [7:0] rises;            // monitor count
  int         err_total = 0;
  int         total_checks = 0;
  // rows: channel, selection, bit3, ready, expected pin
  logic [5:0] rows [8] = '{6'h06, 6'h03, 6'h1E, 6'h10,
                           6'h13, 6'h34, 6'h21, 6'h3B};
  logic [5:0] row;
  always #2 clk = ~clk;
  uart_multi_output_select uart_multi_output_select_i (
    .i_ref_clk(clk), .i_rst_n(rst_n),
    .i_chan_a_alt_func_write(func_w[0]), .i_chan_a_alt_func_wdata(func_d[0]),
    .i_chan_a_modem_ctrl_write(ctrl_w[0]),
    .i_chan_a_modem_ctrl_wdata(ctrl_d[0]),
    .i_chan_a_rate_clock_16x(rate[0]), .i_chan_a_receive_ready_n(rdy[0]),
    .i_chan_b_alt_func_write(func_w[1]), .i_chan_b_alt_func_wdata(func_d[1]),
    .i_chan_b_modem_ctrl_write(ctrl_w[1]),
    .i_chan_b_modem_ctrl_wdata(ctrl_d[1]),
    .i_chan_b_rate_clock_16x(rate[1]), .i_chan_b_receive_ready_n(rdy[1]),
    .i_chan_b_ring_indicator_n(ring_n),
    .o_chan_a_multi_output_n(pin[0]), .o_chan_b_multi_output_n(pin[1]),
    .o_chan_a_sel(), .o_chan_b_sel(), .o_chan_a_user_out_two(),
    .o_chan_b_user_out_two(), .o_chan_b_ring_status_n(ring_st));
  dma_pin_watch dma_pin_watch_i (.i_ref_clk(clk), .i_clear(clr),
    .i_pin_n(pin[0]), .o_rises(rises));
  // compare one value and count it
  task automatic chk(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // write selection and bit 3 with junk in the other bits
  task automatic wr(input int c, input logic [1:0] s, input logic u,
                    input logic r);
    @(negedge clk);
    func_w[c] = 1'b1;
    ctrl_w[c] = 1'b1;
    func_d[c] = 8'hF9 | {5'h00, s, 1'b0};
    ctrl_d[c] = 8'hF7 | {4'h0, u, 3'h0};
    rdy[c] = r;
    @(negedge clk);
    func_w = 2'h0;
    ctrl_w = 2'h0;
    @(negedge clk);
  endtask : wr
  // verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    chk(pin[0], 1'b1, "pin in reset");
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(pin[0], 1'b0, "reset pin a");
    chk(pin[1], 1'b0, "reset pin b");
    foreach (rows[k]) begin
      row = rows[k];
      wr(int'(row[5]), row[4:3], row[2], row[1]);
      chk(pin[row[5]], row[0], "row pin");
    end
    wr(0, 2'h1, 1'b1, 1'b1);
    chk(pin[1], 1'b1, "b kept");
    @(negedge clk);
    clr = 1'b0;
    repeat (16) begin
      @(negedge clk);
      rate[0] = ~rate[0];
    end
    repeat (2) @(negedge clk);
    chk(rises == 8'h08, 1'b1, "rate edges");
    ring_n = 1'b0;
    @(negedge clk);
    ring_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(ring_st, 1'b1, "glitch passed");
    ring_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(ring_st, 1'b0, "ring low");
    chk(pin[1], 1'b1, "b unmoved");
    // mid-run reset: bit 3 and selection must reload
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk(pin[0], 1'b1, "pin a in reset");
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(pin[0], 1'b0, "rearm pin a");
    chk(pin[1], 1'b0, "rearm pin b");
    complete_run();
  end
endmodule : uart_multi_output_select_test
`default_nettype wire
